// [ssp_line_cond.sv]
// Purpose: Synchronises the bus pins and detects edges and conditions.
// Assumes: 40 MHz sampling easily resolves a 400 kbps bus.
// Notes:   Two flops per pin, then a third stage for edge detection.
module ssp_line_cond (
	input  wire logic clk_sys_i, // System clock.
	input  wire logic rst_b_i,   // Asynchronous reset, active low.
	input  wire logic scl_i,     // Raw clock line.
	input  wire logic sda_i,     // Raw data line.
	ssp_line_if.cond  line       // Conditioned line events.
);
	import ssp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Synchroniser; the first stage feeds only the second. Idle lines are high.
	logic [1:0] scl_meta_q, sda_meta_q;
	logic       scl_last_q, sda_last_q;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_meta_q <= 2'h3;
			sda_meta_q <= 2'h3;
			scl_last_q <= 1'b1;
			sda_last_q <= 1'b1;
		end else begin
			scl_meta_q <= {scl_meta_q[0], scl_i};
			sda_meta_q <= {sda_meta_q[0], sda_i};
			scl_last_q <= scl_meta_q[1];
			sda_last_q <= sda_meta_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// A data change while the clock stays high is a start or a stop.
	assign line.scl      = scl_meta_q[1];
	assign line.sda      = sda_meta_q[1];
	assign line.scl_rise = scl_meta_q[1] & ~scl_last_q;
	assign line.scl_fall = ~scl_meta_q[1] & scl_last_q;
	assign line.start    = scl_meta_q[1] & scl_last_q & sda_last_q & ~sda_meta_q[1];
	assign line.stop     = scl_meta_q[1] & scl_last_q & ~sda_last_q & sda_meta_q[1];

endmodule : ssp_line_cond

// [ssp_line_if.sv]
// Purpose: Carries the synchronised bus line levels and their events.
// Assumes: Driven by the line conditioner, read by the protocol engine.
// Notes:   All members are in the system clock domain.
interface ssp_line_if;
	logic scl;      // Synchronised clock line level.
	logic sda;      // Synchronised data line level.
	logic scl_rise; // Clock line rose this cycle.
	logic scl_fall; // Clock line fell this cycle.
	logic start;    // Start or repeated start seen.
	logic stop;     // Stop seen.

	modport cond (output scl, sda, scl_rise, scl_fall, start, stop);
	modport eng  (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : ssp_line_if

// [ssp_mem_stub.sv]
// Purpose: Holds the optional status byte presented in the upper half.
// Assumes: Port lines are asynchronous inputs.
// Notes:   Read data comes from a register, three cycles after the pins.
module ssp_mem_stub (
	input  wire logic       clk_sys_i,   // System clock.
	input  wire logic       rst_b_i,     // Asynchronous reset, active low.
	input  wire logic       port_line_0, // Loss of signal input.
	input  wire logic       port_line_1, // Transmit fault input.
	output logic      [7:0] status_o     // Status byte, registered.
);
	import ssp_pkg::*;

	logic [1:0] pl0_meta_q, pl1_meta_q;
	logic [7:0] status_d, status_q;

	////////////////////////////////////////////////////////////////////////////
	// Only the two flags are ever non zero; nothing can write this byte.
	always_comb begin
		status_d                     = SSP_STATUS_RESET;
		status_d[SSP_STATUS_LOS_BIT] = pl0_meta_q[1];
		status_d[SSP_STATUS_TXF_BIT] = pl1_meta_q[1];
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pl0_meta_q <= 2'h0;
			pl1_meta_q <= 2'h0;
			status_q   <= SSP_STATUS_RESET;
		end else begin
			pl0_meta_q <= {pl0_meta_q[0], port_line_0};
			pl1_meta_q <= {pl1_meta_q[0], port_line_1};
			status_q   <= status_d;
		end
	end

	assign status_o = status_q;

endmodule : ssp_mem_stub

// [ssp_mst_model.sv]
// Purpose: Behavioural two-wire bus master driving clock and data.
// Assumes: Open-drain data; a 1 on sda_m_o releases the line.
// Notes:   Q cycles per quarter bit; 25 gives 400 kbps at 40 MHz.
module ssp_mst_model #(
	parameter int Q = 25 // Cycles per quarter bit.
) (
	input  wire logic clk_sys_i, // System clock.
	input  wire logic sda_w_i,   // Resolved data line.
	output logic      scl_o,     // Clock line, master only.
	output logic      sda_m_o    // Data drive, 1 releases.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus idles with both lines high.
	initial begin
		scl_o = 1'b1;
		sda_m_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Every change lands just after a clock edge.
	task automatic qw();
		repeat (Q) @(posedge clk_sys_i);
	endtask : qw

	// Start from idle, or a repeated start after a byte.
	task automatic start();
		sda_m_o <= 1'b1;
		qw();
		scl_o <= 1'b1;
		qw();
		sda_m_o <= 1'b0;
		qw();
		scl_o <= 1'b0;
		qw();
	endtask : start

	// Data rises while the clock is high.
	task automatic stop();
		sda_m_o <= 1'b0;
		qw();
		scl_o <= 1'b1;
		qw();
		sda_m_o <= 1'b1;
		qw();
	endtask : stop

	// One bit: data moves in the low phase, sampled mid high phase.
	task automatic xbit(input logic b, output logic r);
		sda_m_o <= b;
		qw();
		scl_o <= 1'b1;
		qw();
		r = sda_w_i;
		qw();
		scl_o <= 1'b0;
		qw();
	endtask : xbit

	// Eight bits MSB first, then the acknowledge slot.
	task automatic xbyte(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
			output logic ack);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		xbit(ack_m, ack);
	endtask : xbyte
endmodule : ssp_mst_model

// [ssp_pkg.sv]
// Purpose: Shared constants and types for the two-wire serial slave port.
// Assumes: One system clock at 40 MHz; bus pins arrive asynchronously.
// Notes:   Memory contents live outside; this port only frames bytes.
package ssp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Slave address layout, MSB first on the wire.
	localparam logic [3:0] SSP_ADDR_FAMILY    = 4'hA;
	localparam int         SSP_ADDR_FAM_MSB   = 7;
	localparam int         SSP_ADDR_FAM_LSB   = 4;
	localparam int         SSP_ADDR_STRAP2    = 3;
	localparam int         SSP_ADDR_STRAP1    = 2;
	localparam int         SSP_ADDR_HALF      = 1;
	localparam int         SSP_ADDR_DIR       = 0;

	////////////////////////////////////////////////////////////////////////////
	// Optional status byte in the upper half.
	localparam logic [7:0] SSP_STATUS_OFFSET  = 8'h6E;
	localparam int         SSP_STATUS_LOS_BIT = 1;
	localparam int         SSP_STATUS_TXF_BIT = 2;
	localparam logic [7:0] SSP_STATUS_RESET   = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Control byte fields kept by the memory side and supplied to this port.
	localparam int         SSP_CTRL_OPTIC_BIT = 4;
	localparam int         SSP_CTRL_PROTO_BIT = 6;

	////////////////////////////////////////////////////////////////////////////
	// Timing: slowest SCL high phase is 0.6 us in fast mode (400 kbps).
	localparam int         SSP_CLK_MHZ        = 40;
	localparam int         SSP_T_HIGH_NS      = 600;
	localparam int         SSP_T_HIGH_CYC     = (SSP_T_HIGH_NS * SSP_CLK_MHZ) / 1000;
	localparam int         SSP_BIT_CNT_W      = 4;
	localparam logic [3:0] SSP_ACK_SLOT       = 4'h8;
	localparam logic [3:0] SSP_LAST_SLOT      = 4'h9;

	typedef enum logic [2:0] {
		SSP_ST_IDLE  = 3'b000,
		SSP_ST_ADDR  = 3'b001,
		SSP_ST_WRITE = 3'b010,
		SSP_ST_READ  = 3'b011,
		SSP_ST_IGN   = 3'b100
	} ssp_state_t;

endpackage : ssp_pkg

// [ssp_slave.sv]
// Purpose: Two-wire serial slave front end with address decode and acks.
// Assumes: Memory side supplies read bytes and refusal; pins are async.
// Notes:   Byte data and pointer handling belong to the memory side.

////////////////////////////////////////////////////////////////////////////////
module ssp_slave (
	input  wire logic       clk_sys_i,       // System clock, 40 MHz.
	input  wire logic       rst_b_i,         // Asynchronous reset, active low.
	input  wire logic       scl_i,           // Clock line level.
	input  wire logic       sda_i,           // Data line level.
	output logic            sda_o,           // Data drive value, always 0.
	output logic            sda_oe_b_o,      // Low while pulling data low.
	input  wire logic       strap_addr_bit1, // Address strap pin 1.
	input  wire logic       strap_addr_bit2, // Address strap pin 2.
	input  wire logic       port_line_0,     // Port line feeding loss flag.
	input  wire logic       port_line_1,     // Port line feeding fault flag.
	input  wire logic [7:0] ctrl_i,          // Control byte from memory side.
	input  wire logic       busy_i,          // Memory write cycle running.
	input  wire logic [7:0] rd_data_i,       // Read byte at read pointer.
	input  wire logic       refuse_i,        // Memory refuses current byte.
	input  wire logic [7:0] rd_ptr_i,        // Current byte pointer.
	output logic            sel_o,           // Transfer addressed to us.
	output logic            half_o,          // Selected memory half.
	output logic            dir_rd_o,        // Current access reads.
	output logic            wr_strobe_o,     // Received byte valid pulse.
	output logic            wr_first_o,      // Received byte is the pointer.
	output logic      [7:0] wr_data_o,       // Received byte, registered.
	output logic            rd_strobe_o,     // Byte consumed, advance pointer.
	output logic            stop_o,          // Stop seen pulse.
	output logic      [7:0] status_o         // Optional status byte.
);
	import ssp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Line conditioning and the status byte.
	// Every bus event reaches the engine three system clocks after the pin
	// moves; at 40 MHz that is far inside the shortest clock low phase, so
	// the acknowledge drive still settles before the next rising edge.
	ssp_line_if line ();

	ssp_line_cond u_cond (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.line      (line)
	);

	logic [7:0] status_w;

	ssp_mem_stub u_stat (
		.clk_sys_i   (clk_sys_i),
		.rst_b_i     (rst_b_i),
		.port_line_0 (port_line_0),
		.port_line_1 (port_line_1),
		.status_o    (status_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// Strap pins are sampled through two flops before comparison.
	// They are board straps and should not move, but a pin that floats
	// must still not feed a metastable level into the address match.
	logic [1:0] strap1_meta_q, strap2_meta_q;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap1_meta_q <= 2'h0;
			strap2_meta_q <= 2'h0;
		end else begin
			strap1_meta_q <= {strap1_meta_q[0], strap_addr_bit1};
			strap2_meta_q <= {strap2_meta_q[0], strap_addr_bit2};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers.
	// half_q survives read addressing on purpose: a read always uses the
	// half chosen by the last write addressing. ack_q holds the answer to
	// the byte in flight until its acknowledge slot, and nack_q remembers
	// a master not-acknowledge so that the port falls silent afterwards.
	// first_q marks the pointer byte, the first byte of a write access.
	ssp_state_t state_q, state_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic       half_q, half_d;
	logic       dir_q, dir_d;
	logic       first_q, first_d;
	logic       ack_q, ack_d;
	logic       drive_q, drive_d;
	logic       nack_q, nack_d;
	logic [7:0] wdata_q, wdata_d;
	logic       wstb_q, wstb_d;
	logic       rstb_q, rstb_d;

	////////////////////////////////////////////////////////////////////////////
	// Decode of the address byte and of the active transfer.
	// rx_byte includes the bit on the line now, so a match is known on the
	// eighth rising edge itself. The status location refuses writes only
	// after the pointer byte, so a pointer naming that location still lands.
	// Control bits are levels from the memory side and are not resynchronised.
	wire        smbus_mode   = ctrl_i[SSP_CTRL_PROTO_BIT];
	wire        optic_mode   = ctrl_i[SSP_CTRL_OPTIC_BIT];
	wire [7:0]  rx_byte      = {shift_q[6:0], line.sda};
	wire        fam_hit      = rx_byte[SSP_ADDR_FAM_MSB:SSP_ADDR_FAM_LSB]
	                           == SSP_ADDR_FAMILY;
	wire        strap_hit    = rx_byte[SSP_ADDR_STRAP2] == strap2_meta_q[1]
	                           && rx_byte[SSP_ADDR_STRAP1] == strap1_meta_q[1];
	wire        addr_hit     = fam_hit & strap_hit;
	wire        rx_rd        = rx_byte[SSP_ADDR_DIR];
	wire        status_hit   = optic_mode & half_q & ~first_q
	                           & (rd_ptr_i == SSP_STATUS_OFFSET);
	wire        byte_refuse  = refuse_i | status_hit | (smbus_mode & busy_i);
	wire [7:0]  tx_byte      = (optic_mode & half_q & rd_ptr_i == SSP_STATUS_OFFSET)
	                           ? status_w : rd_data_i;
	wire        data_bit     = bit_q < SSP_ACK_SLOT;

	////////////////////////////////////////////////////////////////////////////
	// Picks the next bit to send, MSB first, after n bits have gone.
	// The shift register is frozen during a read, so the count selects
	// the bit; once the byte is out the line is released for the master.
	function automatic logic tx_bit_sel(input logic [7:0] b, input logic [3:0] n);
		logic [2:0] idx;
		idx = 3'h7 - n[2:0];
		return (n >= SSP_ACK_SLOT) ? 1'b1 : b[idx];
	endfunction : tx_bit_sel

	////////////////////////////////////////////////////////////////////////////
	// Protocol engine; events are one-cycle pulses from the conditioner.
	// The bit counter runs 0 to 7 over the data bits, stands at 8 while
	// the acknowledge slot is pending and at 9 once its clock pulse has risen.
	// Start and stop are checked first, so they cut a byte wherever it is.
	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		shift_d = shift_q;
		half_d  = half_q;
		dir_d   = dir_q;
		first_d = first_q;
		ack_d   = ack_q;
		drive_d = drive_q;
		nack_d  = nack_q;
		wdata_d = wdata_q;
		wstb_d  = 1'b0;
		rstb_d  = 1'b0;
		if (line.start) begin
			state_d = SSP_ST_ADDR;
			bit_d   = 4'h0;
			drive_d = 1'b0;
			nack_d  = 1'b0;
		end else if (line.stop) begin
			state_d = SSP_ST_IDLE;
			bit_d   = 4'h0;
			drive_d = 1'b0;
		end else if (state_q != SSP_ST_IDLE && state_q != SSP_ST_IGN) begin
			if (line.scl_rise) begin
				if (data_bit) begin
					// While sending, keep the byte still; the count picks the bit.
					if (state_q != SSP_ST_READ) begin
						shift_d = rx_byte;
					end
					bit_d   = bit_q + 4'h1;
				end else begin
					// Acknowledge slot: the master answers in a read.
					bit_d  = SSP_LAST_SLOT;
					nack_d = dir_q & line.sda & (state_q == SSP_ST_READ);
				end
				if (data_bit && bit_q == 4'h7) begin
					case (state_q)
						SSP_ST_ADDR: begin
							if (addr_hit) begin
								ack_d = 1'b1;
								dir_d = rx_rd;
								if (!rx_rd) begin
									half_d = rx_byte[SSP_ADDR_HALF];
								end
								first_d = 1'b1;
							end else begin
								ack_d = 1'b0;
							end
						end
						SSP_ST_WRITE: begin
							ack_d   = ~byte_refuse;
							wdata_d = rx_byte;
							wstb_d  = ~byte_refuse;
						end
						default: begin
							ack_d = 1'b0;
						end
					endcase
				end
			end else if (line.scl_fall) begin
				if (bit_q == SSP_ACK_SLOT) begin
					// Data byte done: drive ack low for the next pulse.
					drive_d = (state_q != SSP_ST_READ) & ack_q;
				end else if (bit_q == SSP_LAST_SLOT) begin
					bit_d   = 4'h0;
					drive_d = 1'b0;
					case (state_q)
						SSP_ST_ADDR: begin
							state_d = !ack_q ? SSP_ST_IGN
							        : (dir_q ? SSP_ST_READ : SSP_ST_WRITE);
						end
						SSP_ST_WRITE: begin
							first_d = 1'b0;
						end
						SSP_ST_READ: begin
							rstb_d = 1'b1;
							if (nack_q) begin
								state_d = SSP_ST_IGN;
							end
						end
						default: begin
							state_d = state_q;
						end
					endcase
					if (state_d == SSP_ST_READ) begin
						shift_d = tx_byte;
						drive_d = ~tx_byte[7];
					end
				end else if (state_q == SSP_ST_READ && bit_q != 4'h0) begin
					// Next data bit goes out in the low phase before its pulse.
					drive_d = ~tx_bit_sel(shift_q, bit_q);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State flops; all reset to the idle, released-line values.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= SSP_ST_IDLE;
			bit_q   <= 4'h0;
			shift_q <= 8'h00;
			half_q  <= 1'b0;
			dir_q   <= 1'b0;
			first_q <= 1'b0;
			ack_q   <= 1'b0;
			drive_q <= 1'b0;
			nack_q  <= 1'b0;
			wdata_q <= 8'h00;
			wstb_q  <= 1'b0;
			rstb_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			half_q  <= half_d;
			dir_q   <= dir_d;
			first_q <= first_d;
			ack_q   <= ack_d;
			drive_q <= drive_d;
			nack_q  <= nack_d;
			wdata_q <= wdata_d;
			wstb_q  <= wstb_d;
			rstb_q  <= rstb_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Open-drain output: only ever pulls low, released otherwise.
	// The enable comes straight from a flop, so no decode glitch can put a
	// short low pulse on the data line while the clock is high.
	// The stop pulse is combinational, but only from synchroniser flops.
	assign sda_o       = 1'b0;
	assign sda_oe_b_o  = ~drive_q;
	assign sel_o       = state_q == SSP_ST_WRITE || state_q == SSP_ST_READ;
	assign half_o      = half_q;
	assign dir_rd_o    = dir_q;
	assign wr_strobe_o = wstb_q;
	assign wr_first_o  = first_q;
	assign wr_data_o   = wdata_q;
	assign rd_strobe_o = rstb_q;
	assign stop_o      = line.stop;
	assign status_o    = status_w;

endmodule : ssp_slave

// [ssp_slave_chk.sv]
// Purpose: Concurrent checks on the serial slave port pins.
// Assumes: Sees top-level ports only; one clock domain.
// Notes:   Mirror checks wait out reset and the pin synchronisers.
module ssp_slave_chk (
	input  wire logic       clk_sys_i,   // System clock.
	input  wire logic       rst_b_i,     // Reset, active low.
	input  wire logic       scl_i,       // Clock line.
	input  wire logic       sda_oe_b_o,  // Data pull enable, active low.
	input  wire logic       port_line_0, // Port line 0.
	input  wire logic       port_line_1, // Port line 1.
	input  wire logic       sel_o,       // Selected.
	input  wire logic       half_o,      // Memory half.
	input  wire logic       dir_rd_o,    // Read access.
	input  wire logic       wr_strobe_o, // Write byte pulse.
	input  wire logic       rd_strobe_o, // Read byte pulse.
	input  wire logic       stop_o,      // Stop pulse.
	input  wire logic [7:0] status_o     // Status byte.
);
	logic [3:0] cyc_q; // Cycles since reset, saturating.

	////////////////////////////////////////////////////////////////////////////
	// Count out reset, so that stale synchroniser contents are not judged.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cyc_q <= 4'h0;
		end else if (cyc_q != 4'hF) begin
			cyc_q <= cyc_q + 4'h1;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	////////////////////////////////////////////////////////////////////////////
	// The drive may only move while the clock line is low.
	AST_OE_MOVES_LOW: assert property ($changed(sda_oe_b_o) |-> !scl_i)
		else $error("Data drive changed while clock high.");
	AST_ACK_HOLD: assert property (scl_i && !sda_oe_b_o |=> !sda_oe_b_o)
		else $error("Data drive released during clock high.");
	AST_WR_PULSE: assert property (wr_strobe_o |=> !wr_strobe_o)
		else $error("Write strobe longer than one cycle.");
	AST_WR_DIR: assert property (wr_strobe_o |-> sel_o && !dir_rd_o)
		else $error("Write strobe outside a write access.");
	AST_RD_DIR: assert property (rd_strobe_o |-> dir_rd_o)
		else $error("Read strobe outside a read access.");
	AST_HALF_RD: assert property (sel_o && dir_rd_o |-> $stable(half_o))
		else $error("Half select moved during a read.");
	AST_STOP_IDLE: assert property (stop_o |-> ##[1:4] (!sel_o && sda_oe_b_o))
		else $error("Port not idle after stop.");
	AST_STATUS_ZERO: assert property (status_o[0] == 1'b0 && status_o[7:3] == 5'h00)
		else $error("Unused status bit set.");
	AST_STATUS_LOS: assert property ($stable(port_line_0) [*5] ##0 cyc_q == 4'hF
		|-> status_o[1] == port_line_0) else $error("Loss flag not mirrored.");
	AST_STATUS_TXF: assert property ($stable(port_line_1) [*5] ##0 cyc_q == 4'hF
		|-> status_o[2] == port_line_1) else $error("Fault flag not mirrored.");
endmodule : ssp_slave_chk

// [tb_ssp_slave.sv]
// Purpose: Self-checking bench for the serial slave port.
// Assumes: Strap pins 1 and 2 held at 0 and 1.
// Notes:   Memory-side inputs are steered per scenario.
module tb_ssp_slave;
	timeunit 1ns;
	timeprecision 1ps;
	import ssp_pkg::*;

	logic       clk_sys_i, rst_b_i, s1, s2, pl0, pl1, busy, refuse;
	logic [7:0] ctrl, rd_data, rd_ptr, wr_last, wr_data, status;
	wire logic  scl, sda_m, sda_w, sda_o, sda_oe_b;
	logic       sel, half, dir_rd, wr_stb, wr_first, rd_stb, stop;
	int         errors, checked, wr_cnt, rd_cnt, stp_cnt;

	// Pull-up wins unless someone pulls low.
	assign sda_w = sda_m & (sda_oe_b | sda_o);

	ssp_mst_model #(.Q(25)) mst (.clk_sys_i, .sda_w_i(sda_w), .scl_o(scl),
		.sda_m_o(sda_m));

	ssp_slave DUT (.clk_sys_i, .rst_b_i, .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_b_o(sda_oe_b), .strap_addr_bit1(s1), .strap_addr_bit2(s2),
		.port_line_0(pl0), .port_line_1(pl1), .ctrl_i(ctrl), .busy_i(busy),
		.rd_data_i(rd_data), .refuse_i(refuse), .rd_ptr_i(rd_ptr), .sel_o(sel),
		.half_o(half), .dir_rd_o(dir_rd), .wr_strobe_o(wr_stb), .wr_first_o(wr_first),
		.wr_data_o(wr_data), .rd_strobe_o(rd_stb), .stop_o(stop), .status_o(status));

	////////////////////////////////////////////////////////////////////////////
	// Clock, and a log of received bytes.
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (wr_stb === 1'b1) begin
			wr_cnt++;
			wr_last = wr_data;
		end
		if (rd_stb === 1'b1) begin
			rd_cnt++;
		end
		if (stop === 1'b1) begin
			stp_cnt++;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] adr(input logic h, input logic d);
		return {SSP_ADDR_FAMILY, s2, s1, h, d};
	endfunction : adr

	// Write one byte and judge the acknowledge slot.
	task automatic wb(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic       a;
		mst.xbyte(d, 1'b1, q, a);
		chk(8'(a), 8'(e));
	endtask : wb

	// Read one byte with the given master acknowledge.
	task automatic rb(input logic m, input logic [7:0] e);
		logic [7:0] q;
		logic       a;
		mst.xbyte(8'hFF, m, q, a);
		chk(q, e);
	endtask : rb

	////////////////////////////////////////////////////////////////////////////
	// A wrong family or strap bit gets no acknowledge.
	task automatic t_addr();
		logic [7:0] flip [4] = '{8'h10, 8'h80, 8'h08, 8'h04};
		for (int i = 0; i < 5; i++) begin
			mst.start();
			wb(adr(1'b0, 1'b0) ^ (i < 4 ? flip[i] : 8'h00), i < 4);
			mst.stop();
		end
	endtask : t_addr

	task automatic t_write();
		int n;
		int m;
		n = wr_cnt;
		m = stp_cnt;
		mst.start();
		wb(adr(1'b1, 1'b0), 1'b0);
		chk(8'(wr_first), 8'h01);
		wb(8'h10, 1'b0);
		wb(8'h5A, 1'b0);
		chk(wr_last, 8'h5A);
		chk(8'(wr_cnt - n), 8'h02);
		chk(8'({half, dir_rd, sel, wr_first}), 8'h0A);
		mst.stop();
		chk(8'(sel), 8'h00);
		chk(8'(stp_cnt - m), 8'h01);
	endtask : t_write

	// Pointer write, repeated start, read with the other half bit.
	task automatic t_read();
		int n;
		n = rd_cnt;
		rd_data <= 8'h56;
		mst.start();
		wb(adr(1'b1, 1'b0), 1'b0);
		wb(8'h20, 1'b0);
		mst.start();
		wb(adr(1'b0, 1'b1), 1'b0);
		chk(8'({half, dir_rd}), 8'h03);
		rb(1'b0, 8'h56);
		rb(1'b1, 8'h56);
		chk(8'(sda_oe_b), 8'h01);
		chk(8'(rd_cnt - n), 8'h02);
		mst.stop();
	endtask : t_read

	// Optic mode: status mirrors the port lines and refuses writes.
	task automatic t_status();
		ctrl <= 8'h10;
		rd_ptr <= SSP_STATUS_OFFSET;
		for (int i = 1; i < 3; i++) begin
			{pl1, pl0} <= 2'(i);
			mst.start();
			wb(adr(1'b1, 1'b0), 1'b0);
			wb(SSP_STATUS_OFFSET, 1'b0);
			mst.start();
			wb(adr(1'b1, 1'b1), 1'b0);
			rb(1'b1, {5'h00, 2'(i), 1'b0});
			chk(status, {5'h00, 2'(i), 1'b0});
			mst.stop();
		end
		mst.start();
		wb(adr(1'b1, 1'b0), 1'b0);
		wb(SSP_STATUS_OFFSET, 1'b0);
		wb(8'hFF, 1'b1);
		mst.stop();
		ctrl <= 8'h00;
	endtask : t_status

	// Busy in SMBus mode, then a memory refusal in I2C mode.
	task automatic t_refuse();
		int n;
		n = wr_cnt;
		ctrl <= 8'h40;
		busy <= 1'b1;
		mst.start();
		wb(adr(1'b0, 1'b0), 1'b0);
		wb(8'h30, 1'b1);
		mst.stop();
		ctrl <= 8'h00;
		busy <= 1'b0;
		mst.start();
		wb(adr(1'b0, 1'b0), 1'b0);
		wb(8'h31, 1'b0);
		refuse <= 1'b1;
		wb(8'h32, 1'b1);
		mst.stop();
		refuse <= 1'b0;
		chk(8'(wr_cnt - n), 8'h01);
	endtask : t_refuse

	// Start or stop in mid byte cuts the transfer short.
	task automatic t_abort();
		logic r;
		mst.start();
		wb(adr(1'b0, 1'b0), 1'b0);
		for (int i = 0; i < 4; i++) mst.xbit(1'b0, r);
		mst.start();
		wb(adr(1'b0, 1'b1), 1'b0);
		rb(1'b1, 8'h56);
		mst.start();
		wb(adr(1'b0, 1'b0), 1'b0);
		for (int i = 0; i < 4; i++) mst.xbit(1'b1, r);
		mst.stop();
		chk(8'(sel), 8'h00);
	endtask : t_abort

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; the watchdog span is about 2.7 times the expected run.
	initial begin
		{rst_b_i, s1, s2, pl0, pl1, busy, refuse} = 7'h10;
		{ctrl, rd_data, rd_ptr} = 24'h000000;
		repeat (5) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		t_addr();
		t_write();
		t_read();
		t_status();
		t_refuse();
		t_abort();
		tally_and_finish();
	end
	initial begin
		repeat (90000) @(posedge clk_sys_i);
		errors++;
		tally_and_finish();
	end
endmodule : tb_ssp_slave

bind ssp_slave ssp_slave_chk u_chk (.clk_sys_i, .rst_b_i, .scl_i, .sda_oe_b_o,
	.port_line_0, .port_line_1, .sel_o, .half_o, .dir_rd_o, .wr_strobe_o,
	.rd_strobe_o, .stop_o, .status_o);
